/* File: hdl/chan_cmd_pkg.sv */
// Package: offsets, field positions and timing counts of the channel command/status block
package chan_cmd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FRAME_COUNTS = 8'h10;
  localparam logic [7:0] OFS_COMMAND      = 8'h14;
  localparam logic [7:0] OFS_STATUS       = 8'h18;
  // Command bit positions
  localparam int CMD_TIMER_START  = 0;
  localparam int CMD_TIMER_STOP   = 1;
  localparam int CMD_RESYNC       = 16;
  localparam int CMD_RX_RESET     = 17;
  localparam int CMD_SEND_FRAME   = 24;
  localparam int CMD_SEND_REPEAT  = 25;
  localparam int CMD_STOP_REPEAT  = 26;
  localparam int CMD_TX_RESET     = 27;
  localparam int CMD_SEND_ON_TIME = 28;
  // Status bit positions
  localparam int ST_PINS_LSB      = 0;
  localparam int ST_ABORTED       = 8;
  localparam int ST_CRC_FAIL      = 9;
  localparam int ST_LEN_EXCEEDED  = 10;
  localparam int ST_INVALID       = 11;
  localparam int ST_FRAME_LOST    = 12;
  localparam int ST_DATA_LOST     = 13;
  localparam int ST_TX_EMPTY      = 16;
  localparam int ST_COUNT_FULL    = 17;
  localparam int ST_CMD_BUSY      = 18;
  localparam int ST_UNLOCKED      = 19;
  localparam int ST_REPEAT_ACTIVE = 20;
  localparam int ST_TIMED_ACTIVE  = 21;
  localparam int ST_TX_OVERFLOW   = 24;
  // Frame count field positions and limits
  localparam int FC_TX_LSB        = 16;
  localparam int TX_FRAMES_MAX    = 256;
  localparam int RX_FRAMES_MAX    = 512;
  localparam int TX_FIFO_BYTES    = 4096;
  localparam int RX_FIFO_BYTES    = 8192;
  // Clock-mode code that stalls the transmitter on lost lock
  localparam logic [2:0] CLOCK_MODE_STALL = 3'h5;
  // Command execution time
  localparam int CLK_MHZ          = 100;
  localparam int CMD_EXEC_NS      = 40;
  localparam int CMD_EXEC_CYCLES  = (CMD_EXEC_NS * CLK_MHZ + 999) / 1000;
  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

/* File: hdl/serial_channel_command_status.sv */
// Command, status and queued-frame-count registers of one serial channel
`timescale 1ns/1ns
// Functional notes
// RULE1: Frame count register: 9-bit tx frames high half, 10-bit rx frames low.
// RULE2: Command bits self-clear; only bits written as one act.
// RULE3: Timer start runs timer, pulse per expiry; stop halts and reinitialises.
// RULE4: Resync command drops sync and starts hunting at once.
// RULE5: Receiver reset empties receive FIFO, reinitialises receiver, then accepts data.
// RULE6: Send-frame starts loaded frame with protocol opening sequence prepended.
// RULE7: Repeat-send repeats frame until stopped; active flag reads one meanwhile.
// RULE8: Stop-repeat finishes current frame then stops, never truncating.
// RULE9: Transmitter reset aborts frame, idles, empties FIFO, reinitialises transmitter.
// RULE10: Send-on-timer with send command sends one frame per expiry; flag shows mode. Code sends one frame only unless repeat-send is set.
// RULE11: Bit 24 clears on read; bits 13-8 clear on status push; others live.
// RULE12: Status bits 0-3 mirror CTS, DSR, CD, RI pins live.
// RULE13: Abort flag on abort sequence; CRC flag one on failure, zero on pass.
// RULE14: Length check overrun aborts frame and sets length-exceeded flag.
// RULE15: Invalid flag for non-byte or too-short frames; still ended and stored.
// RULE16: Frame-lost flag when data arrives during unserviced overflow.
// RULE17: Data-lost flag when message overflows receive FIFO.
// RULE18: Transmit-empty flag live while transmit FIFO holds no bytes.
// RULE19: Count-full flag live at 256 queued tx frames; software stops queuing.
// RULE20: Busy flag high during command execution; software waits for zero.
// RULE21: Lost lock sets flag, stops reception, stalls tx in mode 5; clears on frame start.
// RULE22: Transmit-overflow flag on write beyond 4K; clears on status read.
// RULE23: Rx frame length recorded after frame completes, including status word.
module serial_channel_command_status #(
  parameter int TX_FRAMES_MAX = chan_cmd_pkg::TX_FRAMES_MAX,
  parameter int RX_FRAMES_MAX = chan_cmd_pkg::RX_FRAMES_MAX,
  parameter int TIMER_PERIOD  = 1000
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Modem pins
  input  wire logic        CTS,
  input  wire logic        DSR,
  input  wire logic        CD,
  input  wire logic        RI,
  // Channel configuration
  input  wire logic [2:0]  CLOCK_MODE,
  input  wire logic        RECOVERED_CLOCK,
  // Transmit datapath events
  input  wire logic        TX_FIFO_WRITE,
  input  wire logic [12:0] TX_FIFO_LEVEL,
  input  wire logic        TX_FRAME_QUEUED,
  input  wire logic        TX_FRAME_DONE,
  output logic             TX_START,
  output logic             TX_ABORT_IDLE,
  output logic             TX_STALL,
  // Receive datapath events
  input  wire logic        RX_FRAME_START,
  input  wire logic        RX_DATA_BYTE,
  input  wire logic        RX_FIFO_FULL,
  input  wire logic        RX_ABORT_SEEN,
  input  wire logic        RX_LEN_CHECK_EN,
  input  wire logic        RX_LEN_OVER,
  input  wire logic        RX_FRAME_END,
  input  wire logic        RX_CRC_BAD,
  input  wire logic [2:0]  RX_BIT_RESIDUE,
  input  wire logic [15:0] RX_FRAME_BYTES,
  input  wire logic [2:0]  RX_MIN_BYTES,
  input  wire logic        RX_STATUS_PUSH,
  input  wire logic        RX_FRAME_READ,
  input  wire logic        LOCK_LOST,
  output logic             RX_RESYNC_SEARCH_CMD,
  output logic             RX_FLUSH,
  output logic             RX_FRAME_ABORT,
  output logic             RX_LEN_WRITE,
  output logic [15:0]      RX_LEN_VALUE,
  output logic             TIMER_EXPIRED
);

  localparam int TW = $clog2(TIMER_PERIOD + 1);

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b001,
    TX_SEND   = 3'b010,
    TX_WAIT   = 3'b100
  } tx_state_t;

  typedef struct packed {
    logic [2:0]  cts_s, dsr_s, cd_s, ri_s;
    logic [3:0]  pins;
    logic [31:0] rdata;
    logic [8:0]  tx_frames;
    logic [9:0]  rx_frames;
    logic        timer_run;
    logic [TW-1:0] timer_cnt;
    logic        timer_exp;
    tx_state_t   tx_state;
    logic        repeat_on;
    logic        timed_on;
    logic        tx_start;
    logic        tx_abort;
    logic        resync_search_cmd;
    logic        rx_flush;
    logic        rx_abort;
    logic [3:0]  busy_cnt;
    logic        ab, crc, lex, inv, lost_frame, lost_data, overrun_pending;
    logic        unlocked;
    logic        tx_ovf;
    logic        len_wr;
    logic [15:0] len_val;
  } state_t;

  state_t s, next_s;
  logic [1:0] rst_sync;
  logic   rst_n_int;
  logic   cmd_wr, st_rd;
  logic [31:0] c;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n_int = rst_sync[1];

  assign cmd_wr = WR && (ADDR == chan_cmd_pkg::OFS_COMMAND);
  assign st_rd  = RD && (ADDR == chan_cmd_pkg::OFS_STATUS);
  assign c      = cmd_wr ? WDATA : 32'h0000_0000;   // RULE2
  // Compose the status word
  function automatic logic [31:0] status_word(input state_t v, input logic [12:0] lvl,
                                               input logic [8:0] txf);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[3:0]                           = v.pins;                            // RULE12
    w[chan_cmd_pkg::ST_ABORTED]      = v.ab;
    w[chan_cmd_pkg::ST_CRC_FAIL]     = v.crc;
    w[chan_cmd_pkg::ST_LEN_EXCEEDED] = v.lex;
    w[chan_cmd_pkg::ST_INVALID]      = v.inv;
    w[chan_cmd_pkg::ST_FRAME_LOST]   = v.lost_frame;
    w[chan_cmd_pkg::ST_DATA_LOST]    = v.lost_data;
    w[chan_cmd_pkg::ST_TX_EMPTY]     = (lvl == 13'h0000);                 // RULE18
    w[chan_cmd_pkg::ST_COUNT_FULL]   = (txf >= 9'(TX_FRAMES_MAX));        // RULE19
    w[chan_cmd_pkg::ST_CMD_BUSY]     = (v.busy_cnt != 4'h0);              // RULE20
    w[chan_cmd_pkg::ST_UNLOCKED]     = v.unlocked;
    w[chan_cmd_pkg::ST_REPEAT_ACTIVE] = v.repeat_on;                      // RULE7
    w[chan_cmd_pkg::ST_TIMED_ACTIVE] = v.timed_on;                        // RULE10
    w[chan_cmd_pkg::ST_TX_OVERFLOW]  = v.tx_ovf;
    return w;
  endfunction

  // Next-state logic
  always_comb
  begin
    next_s = s;
    // Three-stage pin synchronisers, accept when stages 2 and 3 agree
    next_s.cts_s = {s.cts_s[1:0], CTS};
    next_s.dsr_s = {s.dsr_s[1:0], DSR};
    next_s.cd_s  = {s.cd_s[1:0], CD};
    next_s.ri_s  = {s.ri_s[1:0], RI};
    if (s.cts_s[2] == s.cts_s[1]) next_s.pins[0] = s.cts_s[2];            // RULE12
    if (s.dsr_s[2] == s.dsr_s[1]) next_s.pins[1] = s.dsr_s[2];
    if (s.cd_s[2] == s.cd_s[1])   next_s.pins[2] = s.cd_s[2];
    if (s.ri_s[2] == s.ri_s[1])   next_s.pins[3] = s.ri_s[2];
    next_s.tx_start = 1'b0;
    next_s.tx_abort = 1'b0;
    next_s.resync_search_cmd     = 1'b0;
    next_s.rx_flush = 1'b0;
    next_s.rx_abort = 1'b0;
    next_s.timer_exp = 1'b0;
    next_s.len_wr   = 1'b0;
    if (s.busy_cnt != 4'h0)
      next_s.busy_cnt = s.busy_cnt - 4'h1;
    if (cmd_wr && (WDATA != 32'h0000_0000))
      next_s.busy_cnt = 4'(chan_cmd_pkg::CMD_EXEC_CYCLES);               // RULE20
    // Hardware timer
    if (c[chan_cmd_pkg::CMD_TIMER_START])
    begin
      next_s.timer_run = 1'b1;                                            // RULE3
      next_s.timer_cnt = '0;
    end
    else if (s.timer_run)
    begin
      if (s.timer_cnt == TW'(TIMER_PERIOD - 1))
      begin
        next_s.timer_cnt = '0;
        next_s.timer_exp = 1'b1;                                          // RULE3
      end
      else
        next_s.timer_cnt = s.timer_cnt + 1'b1;
    end
    if (c[chan_cmd_pkg::CMD_TIMER_STOP])
    begin
      next_s.timer_run = 1'b0;                                            // RULE3
      next_s.timer_exp = 1'b0;
      next_s.timer_cnt = '0;
    end
    // Receive commands
    if (c[chan_cmd_pkg::CMD_RESYNC])
      next_s.resync_search_cmd = 1'b1;                                                 // RULE4
    // Queued frame counters, saturating at their documented maxima
    if (TX_FRAME_QUEUED && !TX_FRAME_DONE && s.tx_frames < 9'(TX_FRAMES_MAX))
      next_s.tx_frames = s.tx_frames + 9'h001;                           // RULE1
    else if (TX_FRAME_DONE && !TX_FRAME_QUEUED && s.tx_frames != 9'h000 && !s.repeat_on)
      next_s.tx_frames = s.tx_frames - 9'h001;
    if (RX_FRAME_END && !RX_FRAME_READ && s.rx_frames < 10'(RX_FRAMES_MAX))
      next_s.rx_frames = s.rx_frames + 10'h001;                          // RULE1
    else if (RX_FRAME_READ && !RX_FRAME_END && s.rx_frames != 10'h000)
      next_s.rx_frames = s.rx_frames - 10'h001;
    // Transmit sequencing
    case (s.tx_state)
      TX_IDLE:
      begin
        if (c[chan_cmd_pkg::CMD_SEND_FRAME] || c[chan_cmd_pkg::CMD_SEND_REPEAT])
        begin
          next_s.repeat_on = c[chan_cmd_pkg::CMD_SEND_REPEAT];            // RULE7
          if (c[chan_cmd_pkg::CMD_SEND_ON_TIME])
          begin
            next_s.timed_on = 1'b1;                                       // RULE10
            next_s.tx_state = TX_WAIT;
          end
          else
          begin
            next_s.tx_start = 1'b1;                                       // RULE6
            next_s.tx_state = TX_SEND;
          end
        end
      end
      TX_SEND:
      begin
        if (TX_FRAME_DONE)
        begin
          if (s.repeat_on && s.timed_on)
            next_s.tx_state = TX_WAIT;
          else if (s.repeat_on)
            next_s.tx_start = 1'b1;                                       // RULE7
          else
          begin
            next_s.tx_state = TX_IDLE;                                    // RULE8
            next_s.timed_on = 1'b0;
          end
        end
      end
      TX_WAIT:
      begin
        if (s.timer_exp)
        begin
          next_s.tx_start = 1'b1;                                         // RULE10
          next_s.tx_state = TX_SEND;
        end
        else if (!s.repeat_on)
        begin
          if (!s.timed_on)
            next_s.tx_state = TX_IDLE;
        end
      end
      default:
        next_s.tx_state = TX_IDLE;
    endcase
    if (c[chan_cmd_pkg::CMD_STOP_REPEAT])
    begin
      next_s.repeat_on = 1'b0;                                            // RULE8
      if (s.tx_state == TX_WAIT)
      begin
        next_s.timed_on = 1'b0;
        next_s.tx_state = TX_IDLE;
      end
    end
    if (c[chan_cmd_pkg::CMD_TX_RESET])
    begin
      next_s.tx_abort  = 1'b1;                                            // RULE9
      next_s.tx_start  = 1'b0;
      next_s.repeat_on = 1'b0;
      next_s.timed_on  = 1'b0;
      next_s.tx_frames = 9'h000;
      next_s.tx_state  = TX_IDLE;
    end
    // Per-frame receive flags; push clears, new events in that cycle win
    if (RX_STATUS_PUSH)
    begin
      next_s.ab = 1'b0;                                                   // RULE11
      next_s.crc = 1'b0;
      next_s.lex = 1'b0;
      next_s.inv = 1'b0;
      next_s.lost_frame = 1'b0;
      next_s.lost_data = 1'b0;
      next_s.overrun_pending = 1'b0;
    end
    if (RX_ABORT_SEEN)
      next_s.ab = 1'b1;                                                   // RULE13
    if (RX_FRAME_END)
    begin
      next_s.crc = RX_CRC_BAD;                                            // RULE13
      if (RX_BIT_RESIDUE != 3'h0 || RX_FRAME_BYTES < {13'h0000, RX_MIN_BYTES})
        next_s.inv = 1'b1;                                                // RULE15
    end
    if (RX_LEN_CHECK_EN && RX_LEN_OVER)
    begin
      next_s.lex = 1'b1;                                                  // RULE14
      next_s.rx_abort = 1'b1;
    end
    if (RX_DATA_BYTE && RX_FIFO_FULL)
    begin
      if (s.overrun_pending)
        next_s.lost_frame = 1'b1;                                         // RULE16
      next_s.lost_data = 1'b1;                                            // RULE17
      next_s.overrun_pending = 1'b1;
    end
    // Frame length recorded once the frame is complete, status word included
    if (RX_STATUS_PUSH)
    begin
      next_s.len_wr  = 1'b1;                                              // RULE23
      next_s.len_val = RX_FRAME_BYTES + 16'h0004;
    end
    if (c[chan_cmd_pkg::CMD_RX_RESET])
    begin
      next_s.rx_flush = 1'b1;                                             // RULE5
      next_s.rx_frames = 10'h000;
      next_s.ab = 1'b0;
      next_s.crc = 1'b0;
      next_s.lex = 1'b0;
      next_s.inv = 1'b0;
      next_s.lost_frame = 1'b0;
      next_s.lost_data = 1'b0;
      next_s.overrun_pending = 1'b0;
    end
    // Clock-recovery lock flag
    if (RX_FRAME_START)
      next_s.unlocked = 1'b0;                                             // RULE21
    if (RECOVERED_CLOCK && LOCK_LOST)
      next_s.unlocked = 1'b1;                                             // RULE21
    // Transmit overflow: read clears, new overflow wins
    if (st_rd)
      next_s.tx_ovf = 1'b0;                                               // RULE22
    if (TX_FIFO_WRITE && TX_FIFO_LEVEL >= 13'(chan_cmd_pkg::TX_FIFO_BYTES))
      next_s.tx_ovf = 1'b1;                                               // RULE22
    // Read data, valid in the cycle after the strobe
    next_s.rdata = 32'h0000_0000;
    if (RD)
    begin
      case (ADDR)
        chan_cmd_pkg::OFS_FRAME_COUNTS:
          next_s.rdata = {7'h00, s.tx_frames, 6'h00, s.rx_frames};        // RULE1
        chan_cmd_pkg::OFS_STATUS:
          next_s.rdata = status_word(s, TX_FIFO_LEVEL, s.tx_frames);      // RULE11
        default:
          next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge REF_CLK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      s.cts_s <= 3'h0; s.dsr_s <= 3'h0; s.cd_s <= 3'h0; s.ri_s <= 3'h0;
      s.pins <= 4'h0; s.rdata <= chan_cmd_pkg::RESET_WORD;
      s.tx_frames <= 9'h000; s.rx_frames <= 10'h000;
      s.timer_run <= 1'b0; s.timer_cnt <= '0; s.timer_exp <= 1'b0;
      s.tx_state <= TX_IDLE; s.repeat_on <= 1'b0; s.timed_on <= 1'b0;
      s.tx_start <= 1'b0; s.tx_abort <= 1'b0; s.resync_search_cmd <= 1'b0;
      s.rx_flush <= 1'b0; s.rx_abort <= 1'b0; s.busy_cnt <= 4'h0;
      s.ab <= 1'b0; s.crc <= 1'b0; s.lex <= 1'b0; s.inv <= 1'b0;
      s.lost_frame <= 1'b0; s.lost_data <= 1'b0; s.overrun_pending <= 1'b0;
      s.unlocked <= 1'b0; s.tx_ovf <= 1'b0; s.len_wr <= 1'b0; s.len_val <= 16'h0000;
    end
    else
    begin
      s.cts_s <= next_s.cts_s; s.dsr_s <= next_s.dsr_s;
      s.cd_s <= next_s.cd_s; s.ri_s <= next_s.ri_s;
      s.pins <= next_s.pins; s.rdata <= next_s.rdata;
      s.tx_frames <= next_s.tx_frames; s.rx_frames <= next_s.rx_frames;
      s.timer_run <= next_s.timer_run; s.timer_cnt <= next_s.timer_cnt;
      s.timer_exp <= next_s.timer_exp; s.tx_state <= next_s.tx_state;
      s.repeat_on <= next_s.repeat_on; s.timed_on <= next_s.timed_on;
      s.tx_start <= next_s.tx_start; s.tx_abort <= next_s.tx_abort;
      s.resync_search_cmd <= next_s.resync_search_cmd; s.rx_flush <= next_s.rx_flush;
      s.rx_abort <= next_s.rx_abort; s.busy_cnt <= next_s.busy_cnt;
      s.ab <= next_s.ab; s.crc <= next_s.crc; s.lex <= next_s.lex; s.inv <= next_s.inv;
      s.lost_frame <= next_s.lost_frame; s.lost_data <= next_s.lost_data;
      s.overrun_pending <= next_s.overrun_pending; s.unlocked <= next_s.unlocked;
      s.tx_ovf <= next_s.tx_ovf; s.len_wr <= next_s.len_wr; s.len_val <= next_s.len_val;
    end
  end

  // Outputs
  assign RDATA          = s.rdata;
  assign TX_START       = s.tx_start;
  assign TX_ABORT_IDLE  = s.tx_abort;
  assign TX_STALL       = s.unlocked && (CLOCK_MODE == chan_cmd_pkg::CLOCK_MODE_STALL); // RULE21
  assign RX_RESYNC_SEARCH_CMD        = s.resync_search_cmd || s.unlocked;                           // RULE21
  assign RX_FLUSH       = s.rx_flush;
  assign RX_FRAME_ABORT = s.rx_abort;
  assign RX_LEN_WRITE   = s.len_wr;
  assign RX_LEN_VALUE   = s.len_val;
  assign TIMER_EXPIRED  = s.timer_exp;

endmodule

/* File: testbench/chan_cmd_asserts.sv */
// Concurrent checks on the ports of the channel command/status block
`timescale 1ns/1ns
module chan_cmd_asserts #(
  parameter int TIMER_PERIOD = 1000
) (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        CTS,
  input wire logic        DSR,
  input wire logic        CD,
  input wire logic        RI,
  input wire logic [2:0]  CLOCK_MODE,
  input wire logic        RX_LEN_CHECK_EN,
  input wire logic        RX_LEN_OVER,
  input wire logic        TX_START,
  input wire logic        TX_ABORT_IDLE,
  input wire logic        TX_STALL,
  input wire logic        RX_RESYNC_SEARCH_CMD,
  input wire logic        RX_FLUSH,
  input wire logic        RX_FRAME_ABORT,
  input wire logic        TIMER_EXPIRED
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Decoded command write
  logic cmd_wr;
  assign cmd_wr = WR && ADDR == chan_cmd_pkg::OFS_COMMAND;
  // Pins held still, then a status read
  sequence s_pins_steady;
    $stable({RI, CD, DSR, CTS}) [*6];
  endsequence
  sequence s_status_read;
    RD && ADDR == chan_cmd_pkg::OFS_STATUS;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_PINS_LIVE: assert property (s_pins_steady ##0 s_status_read |=>
    RDATA[3:0] == $past({RI, CD, DSR, CTS})) else $error("pin status wrong");
  AST_SEND_START: assert property (cmd_wr && WDATA[24] && !WDATA[28] && !WDATA[27]
    |=> TX_START) else $error("send frame did not start");
  AST_TX_RESET: assert property (cmd_wr && WDATA[27] |=> TX_ABORT_IDLE)
    else $error("transmitter reset did not abort");
  AST_RX_FLUSH: assert property (RX_FLUSH == $past(cmd_wr && WDATA[17]))
    else $error("receive flush not tied to reset command");
  AST_RESYNC_SEARCH_CMD: assert property (cmd_wr && WDATA[16] |=> RX_RESYNC_SEARCH_CMD)
    else $error("resync command did not resync_search_cmd");
  AST_STALL_MODE: assert property (TX_STALL |-> CLOCK_MODE == 3'h5
    || $past(CLOCK_MODE) == 3'h5) else $error("stall outside mode five");
  AST_TIMER_RUN: assert property (cmd_wr && WDATA[0] && !WDATA[1]
    |-> ##[1:40] TIMER_EXPIRED) else $error("timer never expired");
  AST_TIMER_STOP: assert property (cmd_wr && WDATA[1] && !WDATA[0]
    |=> !TIMER_EXPIRED [*8]) else $error("timer expired after stop");
  AST_LEN_ABORT: assert property (RX_LEN_CHECK_EN && RX_LEN_OVER
    |=> RX_FRAME_ABORT) else $error("length overrun did not abort");
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the channel command/status block
`timescale 1ns/1ns
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, p;
  logic        wr = 1'b0, rd = 1'b0, rec_clk = 1'b0, len_en = 1'b0, rx_full = 1'b0;
  logic        crc_bad = 1'b0;
  logic [3:0]  pins = 4'h0;
  logic [2:0]  clock_mode = 3'h0, residue = 3'h0;
  logic [12:0] tx_level = 13'h0;
  logic [15:0] frm_bytes = 16'h0, len_val;
  // Event pulses: 0 fifo write,1 queued,2 done,3 rx start,4 rx byte,5 abort,
  // 6 len over,7 frame end,8 status push,9 frame read,10 lock lost
  logic [10:0] ev = 11'h0;
  logic        tx_start, tx_abort, tx_stall, rx_resync_search_cmd, rx_flush, rx_fabort, len_wr, tmr;
  int          miscompares = 0, tests_run = 0, cycles = 0, seed = 32'h89AE, starts = 0, k;

  serial_channel_command_status #(.TIMER_PERIOD(8)) i_serial_channel_command_status (
    .REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CTS(pins[0]), .DSR(pins[1]), .CD(pins[2]), .RI(pins[3]),
    .CLOCK_MODE(clock_mode), .RECOVERED_CLOCK(rec_clk), .TX_FIFO_WRITE(ev[0]),
    .TX_FIFO_LEVEL(tx_level), .TX_FRAME_QUEUED(ev[1]), .TX_FRAME_DONE(ev[2]),
    .TX_START(tx_start), .TX_ABORT_IDLE(tx_abort), .TX_STALL(tx_stall),
    .RX_FRAME_START(ev[3]), .RX_DATA_BYTE(ev[4]), .RX_FIFO_FULL(rx_full),
    .RX_ABORT_SEEN(ev[5]), .RX_LEN_CHECK_EN(len_en), .RX_LEN_OVER(ev[6]),
    .RX_FRAME_END(ev[7]), .RX_CRC_BAD(crc_bad), .RX_BIT_RESIDUE(residue),
    .RX_FRAME_BYTES(frm_bytes), .RX_MIN_BYTES(3'h1), .RX_STATUS_PUSH(ev[8]),
    .RX_FRAME_READ(ev[9]), .LOCK_LOST(ev[10]), .RX_RESYNC_SEARCH_CMD(rx_resync_search_cmd), .RX_FLUSH(rx_flush),
    .RX_FRAME_ABORT(rx_fabort), .RX_LEN_WRITE(len_wr), .RX_LEN_VALUE(len_val),
    .TIMER_EXPIRED(tmr));

  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (tx_start === 1'b1) starts <= starts + 1; // Frame starts seen
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // Expected frame count word
  function automatic logic [31:0] cnt_word(int tx, int rx);
    return {7'h0, tx[8:0], 6'h0, rx[9:0]};
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge ref_clk);
  endtask
  // Masked status compare
  task automatic st(logic [31:0] m, logic [31:0] e);
    rd_reg(chan_cmd_pkg::OFS_STATUS, v);
    check(v & m, e);
  endtask
  task automatic pulse(int b);
    ev[b] <= 1'b1;
    @(posedge ref_clk);
    ev <= 11'h0;
    @(posedge ref_clk);
  endtask
  // Command write, then wait out the busy flag
  task automatic cmd(logic [31:0] w);
    wr_reg(chan_cmd_pkg::OFS_COMMAND, w);
    st(32'h0004_0000, 32'h0004_0000);
    repeat (8) if (v[18]) st(32'h0, 32'h0);
    check({31'h0, v[18]}, 32'h0);
  endtask
  task automatic print_verdict();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    // Reset state, unmapped and write-only places
    rd_reg(chan_cmd_pkg::OFS_FRAME_COUNTS, v);
    check(v, cnt_word(0, 0));
    st(32'h0101_3F00, 32'h0001_0000);
    rd_reg(8'h14, v);
    check(v, 32'h0);
    rd_reg(8'h1C, v);
    check(v, 32'h0);
    // Random pins and reserved-only command words
    for (int i = 0; i < 12; i++)
    begin
      p = $random(seed);
      pins <= p[3:0];
      wr_reg(chan_cmd_pkg::OFS_COMMAND, p & 32'hE0FC_FFFC);
      repeat (7) @(posedge ref_clk);
      st(32'h0000_000F, {28'h0, p[3:0]});
    end
    st(32'h0032_0000, 32'h0);
    // Single send from idle
    k = starts;
    cmd(32'h0100_0000);
    pulse(2);
    check(starts - k, 32'h1);
    // Timed single send: one start only, however many expiries
    cmd(32'h0000_0001);
    k = starts;
    cmd(32'h1100_0000);
    st(32'h0020_0000, 32'h0020_0000);
    repeat (20) @(posedge ref_clk);
    check(starts - k, 32'h1);
    pulse(2);
    st(32'h0030_0000, 32'h0);
    cmd(32'h0000_0002);
    // Repeat send restarts per frame end, stop lets the frame finish
    k = starts;
    cmd(32'h0200_0000);
    st(32'h0010_0000, 32'h0010_0000);
    pulse(2);
    st(32'h0010_0000, 32'h0010_0000);
    check(starts - k, 32'h2);
    cmd(32'h0400_0000);
    st(32'h0010_0000, 32'h0);
    pulse(2);
    st(32'h0010_0000, 32'h0);
    check(starts - k, 32'h2);
    // Frame queue filled to the limit
    repeat (256) pulse(1);
    rd_reg(chan_cmd_pkg::OFS_FRAME_COUNTS, v);
    check(v, cnt_word(256, 0));
    st(32'h0002_0000, 32'h0002_0000);
    pulse(2);
    rd_reg(chan_cmd_pkg::OFS_FRAME_COUNTS, v);
    check(v, cnt_word(255, 0));
    st(32'h0002_0000, 32'h0);
    cmd(32'h0800_0000);
    rd_reg(chan_cmd_pkg::OFS_FRAME_COUNTS, v);
    check(v & 32'h01FF_0000, 32'h0);
    st(32'h0030_0000, 32'h0);
    // Receive frame status flags
    crc_bad <= 1'b1;
    residue <= 3'h3;
    frm_bytes <= 16'h0010;
    pulse(5);
    pulse(7);
    st(32'h0000_0B00, 32'h0000_0B00);
    pulse(8);
    st(32'h0000_3F00, 32'h0);
    check({16'h0, len_val}, 32'h0000_0014);
    crc_bad <= 1'b0;
    residue <= 3'h0;
    pulse(7);
    st(32'h0000_0B00, 32'h0);
    frm_bytes <= 16'h0000;
    pulse(7);
    st(32'h0000_0800, 32'h0000_0800);
    len_en <= 1'b1;
    rx_full <= 1'b1;
    pulse(6);
    pulse(4);
    st(32'h0000_2400, 32'h0000_2400);
    pulse(4);
    st(32'h0000_1000, 32'h0000_1000);
    pulse(8);
    st(32'h0000_3F00, 32'h0);
    check({16'h0, len_val}, 32'h0000_0004);
    rd_reg(chan_cmd_pkg::OFS_FRAME_COUNTS, v);
    check(v, cnt_word(0, 3));
    cmd(32'h0003_0000);
    rd_reg(chan_cmd_pkg::OFS_FRAME_COUNTS, v);
    check(v & 32'h0000_03FF, 32'h0);
    // Transmit overflow and empty flag
    tx_level <= 13'h1000;
    pulse(0);
    st(32'h0101_0000, 32'h0100_0000);
    st(32'h0100_0000, 32'h0);
    // Lost clock-recovery lock
    rec_clk <= 1'b1;
    clock_mode <= 3'h5;
    pulse(10);
    st(32'h0008_0000, 32'h0008_0000);
    check({31'h0, tx_stall}, 32'h1);
    pulse(3);
    st(32'h0008_0000, 32'h0);
    print_verdict();
  end
endmodule

bind serial_channel_command_status chan_cmd_asserts #(.TIMER_PERIOD(TIMER_PERIOD))
  i_chan_cmd_asserts (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CTS(CTS), .DSR(DSR), .CD(CD), .RI(RI),
  .CLOCK_MODE(CLOCK_MODE), .RX_LEN_CHECK_EN(RX_LEN_CHECK_EN), .RX_LEN_OVER(RX_LEN_OVER),
  .TX_START(TX_START), .TX_ABORT_IDLE(TX_ABORT_IDLE), .TX_STALL(TX_STALL),
  .RX_RESYNC_SEARCH_CMD(RX_RESYNC_SEARCH_CMD), .RX_FLUSH(RX_FLUSH), .RX_FRAME_ABORT(RX_FRAME_ABORT),
  .TIMER_EXPIRED(TIMER_EXPIRED));
